// >>> verilog/rps_supervisor.sv
// regulator protection supervisor: faults, flags, modes, general outputs
// assumes synchronous comparator inputs and a one-cycle register port
`timescale 1ns/1ps
`include "rps_params.svh"

module rps_supervisor import rps_pkg::*; #(
	parameter int SHORT_CYCLES = `RPS_CYC_US(`RPS_SHORT_US)
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// comparators: buck0, buck1, linreg0, linreg1
	input wire logic [3:0] i_out_low,
	input wire logic i_uv_low,
	input wire logic i_ov_raw,
	input wire logic i_hot_raw,
	input wire logic i_en_pin,
	// regulator drive
	output logic [3:0] o_reg_on,
	output logic [3:0] o_reg_hiz,
	output logic [3:0] o_reg_pulldown,
	// interrupt and mode
	output logic o_irq_pin_low_n,
	output logic [3:0] o_mode,
	// general outputs
	output logic o_general_out_one,
	output logic o_general_out_one_oe_n,
	input wire logic i_general_out_two_in,
	output logic o_general_out_two,
	output logic o_general_out_two_oe_n,
	output logic o_external_clock_in
);

	// ==========================================================
	// constants and state
	localparam logic [19:0] C_SYNC = 20'(`RPS_CYC_US(`RPS_SYNC_US));
	localparam logic [19:0] C_OV_ON = 20'(`RPS_CYC_US(`RPS_OV_ON_US));
	localparam logic [19:0] C_OV_OFF = 20'(`RPS_CYC_US(`RPS_OV_OFF_US));
	localparam logic [19:0] C_HOT = 20'(`RPS_CYC_US(`RPS_HOT_US));
	localparam logic [19:0] C_SHORT = 20'(SHORT_CYCLES);

	rps_mode_type mode_r, mode_nxt;
	logic [7:0] regctrl_r, gpoctrl_r, mask_r;
	logic [6:0] flags_r, flags_nxt, flag_set, flag_clr;
	logic [3:0] run_r, run_nxt, trip;
	logic [19:0] tick_cnt_r, ov_cnt_r, hot_cnt_r, otp_cnt_r;
	logic [19:0] sc_cnt_r [4];
	logic en_sync_r, uv_rel_r, ov_stat_r, hot_stat_r, rst_pend_r;
	logic tick, monitor, block, swreset, defaults, otp_done, regs_open;
	logic lvl1, lvl2;
	logic [7:0] rdata_nxt;

	function automatic logic [19:0] deb_cnt(input logic [19:0] cnt, input logic act);
		return act ? cnt + `RPS_CNT_ONE : 20'h0_0000;
	endfunction

	function automatic logic deb_hit(input logic [19:0] cnt, input logic act,
			input logic [19:0] lim);
		return act && (cnt == lim - `RPS_CNT_ONE);
	endfunction

	assign regs_open = (mode_r == RPS_STANDBY) || (mode_r == RPS_ACTIVE);
	assign monitor = regs_open;
	assign swreset = regs_open && i_wr && (i_addr == `RPS_A_RESET) && i_wdata[`RPS_F_SWRST];
	assign defaults = (mode_r == RPS_SHUTDOWN) || (mode_r == RPS_OTP_LOAD) || swreset;
	assign otp_done = (mode_r == RPS_OTP_LOAD) && (otp_cnt_r == `RPS_OTP_LOAD_CYCLES);
	assign block = ov_stat_r || flags_r[`RPS_F_OVP] || hot_stat_r || flags_r[`RPS_F_HOT];
	assign tick = (tick_cnt_r == C_SYNC - `RPS_CNT_ONE);

	// ==========================================================
	// enable pin and supply release sampling
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt_r <= 20'h0_0000;
		end else begin
			tick_cnt_r <= tick ? 20'h0_0000 : tick_cnt_r + `RPS_CNT_ONE;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			en_sync_r <= 1'b0;
			uv_rel_r <= 1'b0;
		end else begin
			if (tick) begin
				en_sync_r <= i_en_pin;
			end
			if (i_uv_low) begin
				uv_rel_r <= 1'b0;
			end else if (tick) begin
				uv_rel_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// overvoltage and overheat filters
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ov_cnt_r <= 20'h0_0000;
			ov_stat_r <= 1'b0;
		end else if (deb_hit(ov_cnt_r, i_ov_raw != ov_stat_r,
				ov_stat_r ? C_OV_OFF : C_OV_ON)) begin
			ov_cnt_r <= 20'h0_0000;
			ov_stat_r <= i_ov_raw;
		end else begin
			ov_cnt_r <= deb_cnt(ov_cnt_r, i_ov_raw != ov_stat_r);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			hot_cnt_r <= 20'h0_0000;
			hot_stat_r <= 1'b0;
		end else if (deb_hit(hot_cnt_r, i_hot_raw != hot_stat_r, C_HOT)) begin
			hot_cnt_r <= 20'h0_0000;
			hot_stat_r <= i_hot_raw;
		end else begin
			hot_cnt_r <= deb_cnt(hot_cnt_r, i_hot_raw != hot_stat_r);
		end
	end

	// ==========================================================
	// short timers, one per regulator
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			trip[i] = deb_hit(sc_cnt_r[i], run_r[i] && i_out_low[i], C_SHORT);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 4; i++) begin
				sc_cnt_r[i] <= 20'h0_0000;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				sc_cnt_r[i] <= deb_cnt(sc_cnt_r[i], run_r[i] && i_out_low[i] && !trip[i]);
			end
		end
	end

	// ==========================================================
	// regulator control
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// restart follows automatically once the short flag is cleared
			run_nxt[i] = regs_open && !i_uv_low && !swreset && regctrl_r[i] && !block
				&& !trip[i] && !flags_r[i];
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			run_r <= 4'h0;
			o_reg_hiz <= 4'hF;
			o_reg_pulldown <= 4'h0;
		end else begin
			run_r <= run_nxt;
			o_reg_hiz <= ~run_nxt;
			o_reg_pulldown <= ~run_nxt & regctrl_r[`RPS_F_DIS_LO +: 4];
		end
	end

	assign o_reg_on = run_r;

	// ==========================================================
	// device modes
	always_comb begin
		mode_nxt = mode_r;
		if (i_uv_low) begin
			mode_nxt = RPS_SHUTDOWN;
		end else begin
			unique case (mode_r)
				RPS_SHUTDOWN: begin
					if (uv_rel_r) begin
						mode_nxt = RPS_OTP_LOAD;
					end
				end
				RPS_OTP_LOAD: begin
					if (otp_done) begin
						mode_nxt = RPS_STANDBY;
					end
				end
				RPS_STANDBY, RPS_ACTIVE: begin
					if (swreset) begin
						mode_nxt = RPS_OTP_LOAD;
					end else begin
						mode_nxt = (|run_nxt) ? RPS_ACTIVE : RPS_STANDBY;
					end
				end
				default: begin
					mode_nxt = RPS_SHUTDOWN;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mode_r <= RPS_SHUTDOWN;
			otp_cnt_r <= 20'h0_0000;
		end else begin
			mode_r <= mode_nxt;
			otp_cnt_r <= (mode_r == RPS_OTP_LOAD) ? otp_cnt_r + `RPS_CNT_ONE : 20'h0_0000;
		end
	end

	assign o_mode = mode_r;

	// ==========================================================
	// configuration registers, defaults while shutdown or loading
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			regctrl_r <= `RPS_REGCTRL_RST;
			gpoctrl_r <= `RPS_GPOCTRL_RST;
			mask_r <= `RPS_MASK_RST;
		end else if (defaults) begin
			regctrl_r <= `RPS_REGCTRL_RST;
			gpoctrl_r <= `RPS_GPOCTRL_RST;
			mask_r <= `RPS_MASK_RST;
		end else if (i_wr) begin
			if (i_addr == `RPS_A_REGCTRL) begin
				regctrl_r <= i_wdata;
			end
			if (i_addr == `RPS_A_GPOCTRL) begin
				gpoctrl_r <= i_wdata;
			end
			if (i_addr == `RPS_A_MASK) begin
				mask_r <= i_wdata;
			end
		end
	end

	// ==========================================================
	// interrupt flags, set wins over clear
	always_comb begin
		flag_set = {7{1'b0}};
		flag_set[3:0] = trip;
		flag_set[`RPS_F_OVP] = monitor && ov_stat_r;
		flag_set[`RPS_F_HOT] = monitor && hot_stat_r;
		flag_set[`RPS_F_RSTREG] = otp_done && rst_pend_r
			&& !(|(`RPS_MASK_RST & (8'h01 << `RPS_F_RSTREG)));
		flag_clr = (regs_open && i_wr && (i_addr == `RPS_A_FLAGS)) ? i_wdata[6:0] : 7'h00;
		flag_clr[`RPS_F_OVP] = flag_clr[`RPS_F_OVP] && !ov_stat_r;
		flag_clr[`RPS_F_HOT] = flag_clr[`RPS_F_HOT] && !hot_stat_r;
		flags_nxt = ((defaults ? `RPS_FLAGS_RST : flags_r) & ~flag_clr) | flag_set;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			flags_r <= `RPS_FLAGS_RST;
			rst_pend_r <= 1'b1;
			o_irq_pin_low_n <= 1'b1;
		end else begin
			flags_r <= flags_nxt;
			if ((mode_r == RPS_SHUTDOWN) || swreset) begin
				rst_pend_r <= 1'b1;
			end else if (otp_done) begin
				rst_pend_r <= 1'b0;
			end
			o_irq_pin_low_n <= ~|(flags_r & ~mask_r[6:0]);
		end
	end

	// ==========================================================
	// general outputs
	always_comb begin
		lvl1 = gpoctrl_r[`RPS_F_OUT1_SEQ] ? en_sync_r : gpoctrl_r[`RPS_F_OUT1_LEVEL];
		lvl2 = gpoctrl_r[`RPS_F_OUT2_SEQ] ? en_sync_r : gpoctrl_r[`RPS_F_OUT2_LEVEL];
		if (!regs_open || ov_stat_r || flags_r[`RPS_F_OVP]) begin
			lvl1 = 1'b0;
			lvl2 = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_general_out_one <= 1'b0;
			o_general_out_one_oe_n <= 1'b0;
			o_general_out_two <= 1'b0;
			o_general_out_two_oe_n <= 1'b0;
			o_external_clock_in <= 1'b0;
		end else begin
			o_general_out_one <= gpoctrl_r[`RPS_F_OUT1_OD] ? 1'b0 : lvl1;
			o_general_out_one_oe_n <= gpoctrl_r[`RPS_F_OUT1_OD] && lvl1;
			if (gpoctrl_r[`RPS_F_PIN_SEL]) begin
				o_general_out_two <= 1'b0;
				o_general_out_two_oe_n <= 1'b1;
				o_external_clock_in <= i_general_out_two_in;
			end else begin
				o_general_out_two <= gpoctrl_r[`RPS_F_OUT2_OD] ? 1'b0 : lvl2;
				o_general_out_two_oe_n <= gpoctrl_r[`RPS_F_OUT2_OD] && lvl2;
				o_external_clock_in <= 1'b0;
			end
		end
	end

	// ==========================================================
	// read port
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`RPS_A_REGCTRL: rdata_nxt = regctrl_r;
				`RPS_A_GPOCTRL: rdata_nxt = gpoctrl_r;
				`RPS_A_FLAGS: rdata_nxt = {1'b0, flags_r};
				`RPS_A_SUMMARY: rdata_nxt = {4'h0, flags_r[3:0]};
				`RPS_A_STATUS: rdata_nxt = {2'h0, hot_stat_r, ov_stat_r, run_r};
				`RPS_A_MASK: rdata_nxt = mask_r;
				`RPS_A_MODE: rdata_nxt = {4'h0, mode_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= rdata_nxt;
		end
	end

	// ==========================================================
	// checks
	property p_pulldown_only_off;
		@(posedge i_mclk) disable iff (i_rst) o_reg_pulldown[0] |-> o_reg_hiz[0] && !o_reg_on[0];
	endproperty
	a_pulldown_only_off: assert property (p_pulldown_only_off) else $error("pulldown on live output");

	property p_short_trip;
		@(posedge i_mclk) disable iff (i_rst)
			(run_r[0] && i_out_low[0] && sc_cnt_r[0] == C_SHORT - `RPS_CNT_ONE)
			|=> !run_r[0] && flags_r[0];
	endproperty
	a_short_trip: assert property (p_short_trip) else $error("short timer did not trip");

	property p_short_irq;
		@(posedge i_mclk) disable iff (i_rst)
			$rose(flags_r[2]) && !mask_r[2] |=> !o_irq_pin_low_n;
	endproperty
	a_short_irq: assert property (p_short_irq) else $error("short flag gave no interrupt");

	property p_ov_kill;
		@(posedge i_mclk) disable iff (i_rst)
			ov_stat_r && regs_open && !i_uv_low |=> run_r == 4'h0 && flags_r[`RPS_F_OVP];
	endproperty
	a_ov_kill: assert property (p_ov_kill) else $error("overvoltage left regulator on");

	property p_ov_sticky;
		@(posedge i_mclk) disable iff (i_rst)
			ov_stat_r && flags_r[`RPS_F_OVP] && !defaults |=> flags_r[`RPS_F_OVP];
	endproperty
	a_ov_sticky: assert property (p_ov_sticky) else $error("overvoltage flag cleared early");

	property p_ov_filter;
		@(posedge i_mclk) disable iff (i_rst)
			$rose(ov_stat_r) |-> $past(i_ov_raw) && $past(i_ov_raw, C_OV_ON);
	endproperty
	a_ov_filter: assert property (p_ov_filter) else $error("overvoltage rose too soon");

	property p_hot_block;
		@(posedge i_mclk) disable iff (i_rst)
			(hot_stat_r || flags_r[`RPS_F_HOT]) ##1 1'b1 |-> run_r == 4'h0;
	endproperty
	a_hot_block: assert property (p_hot_block) else $error("regulator on during overheat");

	property p_uv_shutdown;
		@(posedge i_mclk) disable iff (i_rst)
			i_uv_low |=> mode_r == RPS_SHUTDOWN && run_r == 4'h0;
	endproperty
	a_uv_shutdown: assert property (p_uv_shutdown) else $error("undervoltage not acted on");

	property p_otp_off;
		@(posedge i_mclk) disable iff (i_rst) mode_r == RPS_OTP_LOAD |-> run_r == 4'h0;
	endproperty
	a_otp_off: assert property (p_otp_off) else $error("regulator on during load");

	property p_active_mode;
		@(posedge i_mclk) disable iff (i_rst)
			regs_open |-> (mode_r == RPS_ACTIVE) == (|run_r);
	endproperty
	a_active_mode: assert property (p_active_mode) else $error("mode disagrees with regulators");

	property p_irq_pin;
		@(posedge i_mclk) disable iff (i_rst)
			(|(flags_r & ~mask_r[6:0])) |=> !o_irq_pin_low_n;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not asserted");

endmodule

// >>> verilog/rps_params.svh
// constants for the regulator protection supervisor
// assumes a 25 MHz system clock and an 8-bit register port
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// ==========================================================
// timing
`define RPS_CLK_PERIOD_NS 40
`define RPS_CYC_US(us) ((((us) * 1000) + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS)
`define RPS_SYNC_US 3
`define RPS_OV_ON_US 1
`define RPS_OV_OFF_US 20
`define RPS_HOT_US 20
`define RPS_SHORT_US 1000
`define RPS_OTP_LOAD_CYCLES 20'h0_0010
`define RPS_CNT_ONE 20'h0_0001

// ==========================================================
// register addresses
`define RPS_A_REGCTRL 8'h00
`define RPS_A_GPOCTRL 8'h01
`define RPS_A_FLAGS 8'h02
`define RPS_A_SUMMARY 8'h03
`define RPS_A_STATUS 8'h04
`define RPS_A_MASK 8'h05
`define RPS_A_RESET 8'h06
`define RPS_A_MODE 8'h07

// ==========================================================
// field positions
`define RPS_F_DIS_LO 4
`define RPS_F_OUT1_LEVEL 0
`define RPS_F_OUT2_LEVEL 1
`define RPS_F_OUT1_OD 2
`define RPS_F_OUT2_OD 3
`define RPS_F_OUT1_SEQ 4
`define RPS_F_OUT2_SEQ 5
`define RPS_F_PIN_SEL 6
`define RPS_F_OVP 4
`define RPS_F_HOT 5
`define RPS_F_RSTREG 6
`define RPS_F_SWRST 0

// ==========================================================
// reset values
`define RPS_REGCTRL_RST 8'hF0
`define RPS_GPOCTRL_RST 8'h00
`define RPS_MASK_RST 8'h00
`define RPS_FLAGS_RST 7'h00

`endif

// >>> verilog/rps_pkg.sv
// types for the regulator protection supervisor
// assumes nothing beyond a SystemVerilog compiler
package rps_pkg;

	// ==========================================================
	// device modes
	typedef enum logic [3:0] {
		RPS_SHUTDOWN = 4'h1,
		RPS_OTP_LOAD = 4'h2,
		RPS_STANDBY = 4'h4,
		RPS_ACTIVE = 4'h8
	} rps_mode_type;

endpackage

// >>> sim/rps_host.sv
// host model: register port master that services the supervisor
// assumes one clock; strobes change by non-blocking assignment after rising edges
`timescale 1ns/1ps
`include "rps_params.svh"

module rps_host (
	// clock
	input wire logic i_mclk,
	// register port
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [7:0] i_rdata
);
	// ==========================================================
	// idle bus
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// ==========================================================
	// one-cycle write, released bus shows inverted values
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	// one-cycle read, data taken in the following cycle
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_mclk);
		d = i_rdata;
	endtask

	// write one to clear a serviced flag
	task automatic clear_flag(input int b);
		wr_reg(`RPS_A_FLAGS, 8'h01 << b);
	endtask
endmodule

// >>> sim/test_regulator_protection_supervisor.sv
// testbench for the regulator protection supervisor
// assumes the host model and a 25 MHz clock; short filter shortened to 20 cycles
`timescale 1ns/1ps
`include "rps_params.svh"

module test_regulator_protection_supervisor;
	import rps_pkg::*;
	localparam int SHORT = 20;
	logic i_mclk, i_rst, i_wr, i_rd, i_uv_low, i_ov_raw, i_hot_raw, i_en_pin, i_gp2_in;
	logic [7:0] i_addr, i_wdata, o_rdata, c, d;
	logic [3:0] i_out_low, o_reg_on, o_reg_hiz, o_reg_pulldown, o_mode;
	logic o_irq_n, o_g1, o_g1_oe_n, o_g2, o_g2_oe_n, o_clk_in;
	logic [15:0] dflt [6];
	logic [7:0] gctl [5];
	logic [4:0] gexp [5];
	int error_cnt, checked, cycles, i;

	// ==========================================================
	// design and host
	rps_supervisor #(.SHORT_CYCLES(SHORT)) uut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_out_low(i_out_low), .i_uv_low(i_uv_low), .i_ov_raw(i_ov_raw),
		.i_hot_raw(i_hot_raw), .i_en_pin(i_en_pin), .o_reg_on(o_reg_on),
		.o_reg_hiz(o_reg_hiz), .o_reg_pulldown(o_reg_pulldown), .o_irq_pin_low_n(o_irq_n),
		.o_mode(o_mode), .o_general_out_one(o_g1), .o_general_out_one_oe_n(o_g1_oe_n),
		.i_general_out_two_in(i_gp2_in), .o_general_out_two(o_g2),
		.o_general_out_two_oe_n(o_g2_oe_n), .o_external_clock_in(o_clk_in));
	rps_host host (.i_mclk(i_mclk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
		.o_rd(i_rd), .i_rdata(o_rdata));

	// ==========================================================
	// clock and timeout
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	// ==========================================================
	// helpers
	task automatic summarize;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd_reg(a, d);
		chk(d, exp, "register read");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wait_mode(input logic [3:0] m);
		int k;
		for (k = 0; k < 300 && o_mode !== m; k++) @(posedge i_mclk);
		chk({4'h0, o_mode}, {4'h0, m}, "mode");
	endtask
	task automatic set_raw(input int b, input logic v);
		if (b == 4) begin
			i_ov_raw <= v;
		end else begin
			i_hot_raw <= v;
		end
	endtask
	// overvoltage (b=4) or overheat (b=5) trip, sticky flag, blocking, clear
	task automatic hazard(input int b, input int ton, input int toff);
		host.wr_reg(`RPS_A_GPOCTRL, 8'h01);
		host.wr_reg(`RPS_A_REGCTRL, 8'hF1);
		cyc(3);
		set_raw(b, 1'b1);
		cyc(ton - 5);
		chk({7'h0, o_reg_on[0]}, 8'h01, "filter early");
		cyc(15);
		chk({4'h0, o_reg_on}, 8'h00, "regulators off");
		chk({4'h0, o_reg_hiz}, 8'h0F, "high-z");
		chk({4'h0, o_reg_pulldown}, 8'h0F, "pulldown");
		chk({4'h0, o_mode}, 8'h04, "standby");
		if (b == 4) chk({7'h0, o_g1}, 8'h00, "general out low");
		chk({7'h0, o_irq_n}, 8'h00, "irq");
		rchk(`RPS_A_FLAGS, 8'h01 << b);
		rchk(`RPS_A_STATUS, 8'h01 << b);
		host.clear_flag(b);
		rchk(`RPS_A_FLAGS, 8'h01 << b);
		host.wr_reg(`RPS_A_REGCTRL, 8'hF1);
		cyc(3);
		chk({4'h0, o_reg_on}, 8'h00, "blocked live");
		set_raw(b, 1'b0);
		cyc(toff + 10);
		rchk(`RPS_A_STATUS, 8'h00);
		host.wr_reg(`RPS_A_REGCTRL, 8'hF1);
		cyc(3);
		chk({4'h0, o_reg_on}, 8'h00, "blocked pending");
		host.clear_flag(b);
		rchk(`RPS_A_FLAGS, 8'h00);
		host.wr_reg(`RPS_A_REGCTRL, 8'hF1);
		cyc(3);
		chk({4'h0, o_reg_on}, 8'h01, "enable again");
		host.wr_reg(`RPS_A_REGCTRL, 8'hF0);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		error_cnt = 0;
		checked = 0;
		cycles = 0;
		i_rst = 1'b1;
		i_out_low = 4'h0;
		i_uv_low = 1'b0;
		i_ov_raw = 1'b0;
		i_hot_raw = 1'b0;
		i_en_pin = 1'b1;
		i_gp2_in = 1'b1;
		dflt = '{16'h0240, 16'h00F0, 16'h0100, 16'h0500, 16'h0400, 16'h0900};
		gctl = '{8'h00, 8'h03, 8'h0F, 8'h0C, 8'h41};
		gexp = '{5'h00, 5'h14, 5'h0A, 5'h00, 5'h13};
		cyc(16);
		i_rst <= 1'b0;
		wait_mode(RPS_OTP_LOAD);
		chk({4'h0, o_reg_on}, 8'h00, "otp load off");
		wait_mode(RPS_STANDBY);
		for (i = 0; i < 6; i++) rchk(dflt[i][15:8], dflt[i][7:0]);
		chk({7'h0, o_irq_n}, 8'h00, "reset flag irq");
		host.wr_reg(`RPS_A_MASK, 8'h40);
		cyc(3);
		chk({7'h0, o_irq_n}, 8'h01, "masked");
		host.wr_reg(`RPS_A_MASK, 8'h00);
		host.clear_flag(6);
		cyc(3);
		chk({7'h0, o_irq_n}, 8'h01, "irq released");
		for (i = 0; i < 5; i++) begin
			host.wr_reg(`RPS_A_GPOCTRL, gctl[i]);
			cyc(3);
			chk({3'h0, o_g1, o_g1_oe_n, o_g2, o_g2_oe_n, o_clk_in}, {3'h0, gexp[i]}, "gpo");
		end
		i_gp2_in <= 1'b0;
		cyc(3);
		chk({7'h0, o_clk_in}, 8'h00, "clock input follows pin");
		host.wr_reg(`RPS_A_GPOCTRL, 8'h30);
		cyc(3);
		chk({3'h0, o_g1, o_g1_oe_n, o_g2, o_g2_oe_n, o_clk_in}, 8'h14, "follow en high");
		i_en_pin <= 1'b0;
		cyc(80);
		chk({3'h0, o_g1, o_g1_oe_n, o_g2, o_g2_oe_n, o_clk_in}, 8'h00, "follow en low");
		i_en_pin <= 1'b1;
		host.wr_reg(`RPS_A_GPOCTRL, 8'h00);
		for (i = 0; i < 4; i++) begin
			c = 8'h01 << i;
			if (!i[0]) c = c | (8'h10 << i);
			host.wr_reg(`RPS_A_REGCTRL, c);
			cyc(3);
			chk({4'h0, o_reg_on}, {4'h0, c[3:0]}, "enabled");
			chk({4'h0, o_mode}, 8'h08, "active");
			i_out_low <= c[3:0];
			cyc(SHORT - 4);
			i_out_low <= 4'h0;
			cyc(1);
			i_out_low <= c[3:0];
			chk({4'h0, o_reg_on}, {4'h0, c[3:0]}, "glitch kept");
			cyc(SHORT + 6);
			chk({4'h0, o_reg_on}, 8'h00, "short off");
			chk({4'h0, o_reg_hiz}, 8'h0F, "high-z");
			chk({4'h0, o_reg_pulldown}, {4'h0, c[7:4]}, "pulldown");
			chk({7'h0, o_irq_n}, 8'h00, "irq");
			rchk(`RPS_A_FLAGS, {4'h0, c[3:0]});
			rchk(`RPS_A_SUMMARY, {4'h0, c[3:0]});
			rchk(`RPS_A_STATUS, 8'h00);
			i_out_low <= 4'h0;
			host.clear_flag(i);
			cyc(2);
			chk({4'h0, o_reg_on}, {4'h0, c[3:0]}, "restart");
			chk({7'h0, o_irq_n}, 8'h01, "irq released");
			host.wr_reg(`RPS_A_REGCTRL, 8'hF0);
		end
		hazard(4, 25, 500);
		hazard(5, 500, 500);
		host.wr_reg(`RPS_A_REGCTRL, 8'hF3);
		cyc(3);
		i_uv_low <= 1'b1;
		cyc(2);
		chk({4'h0, o_mode}, 8'h01, "shutdown");
		chk({4'h0, o_reg_on}, 8'h00, "uv off");
		i_uv_low <= 1'b0;
		wait_mode(RPS_STANDBY);
		rchk(`RPS_A_FLAGS, 8'h40);
		rchk(`RPS_A_REGCTRL, 8'hF0);
		host.clear_flag(6);
		host.wr_reg(`RPS_A_GPOCTRL, 8'h03);
		host.wr_reg(`RPS_A_RESET, 8'h01);
		wait_mode(RPS_OTP_LOAD);
		wait_mode(RPS_STANDBY);
		rchk(`RPS_A_GPOCTRL, 8'h00);
		rchk(`RPS_A_FLAGS, 8'h40);
		summarize();
	end
endmodule
